// [design/ssdr_core.sv]
// Serial port register block: APB slave, status flags, shift engine.
// Assumes one pclk domain; serial pins are asynchronous and synchronised.
`timescale 1ns/1ps
module ssdr_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i
);

  typedef struct packed {
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic sck_prev;
    logic [7:0] ctrl;
    logic done;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic output_disable_bit;
    logic select_software_mgmt_bit;
    logic internal_select_level_bit;
    logic seq_any;
    logic seq_rd;
    logic seq_mode_fault_flag;
    logic [7:0] sr;
    logic [7:0] rxbuf;
    logic out_r;
    logic [4:0] edge_cnt;
    ssdr_pkg::ssdr_eng_e eng;
    logic [5:0] div_cnt;
    logic sck_ph;
    logic [7:0] rdata;
  } ssdr_state_s;

  ssdr_state_s s_r;
  ssdr_state_s s_nxt;

  ////////////////////////////////////////////////////////////////////
  // Bus decode

  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic setup;
  logic is_data;
  logic is_ctrl;
  logic is_csr;

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign is_data = paddr == ssdr_pkg::A_DATA;
  assign is_ctrl = paddr == ssdr_pkg::A_CTRL;
  assign is_csr = paddr == ssdr_pkg::A_CSR;
  assign hit = is_data | is_ctrl | is_csr;
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = {24'h000000, s_r.rdata};

  ////////////////////////////////////////////////////////////////////
  // Derived controls; sync order: 3 sck, 2 mosi, 1 miso, 0 select

  logic serial_output_enable;
  logic master_select_bit;
  logic cpol;
  logic cpha;
  logic ss_int;
  logic rx_in;
  logic slave_act;
  logic busy;
  logic [2:0] rate;
  logic [5:0] half;

  assign serial_output_enable = s_r.ctrl[ssdr_pkg::C_SPE];
  assign master_select_bit = s_r.ctrl[ssdr_pkg::C_MASTER_SELECT_BIT];
  assign cpol = s_r.ctrl[ssdr_pkg::C_CPOL];
  assign cpha = s_r.ctrl[ssdr_pkg::C_CPHA];
  assign ss_int = s_r.select_software_mgmt_bit ? s_r.internal_select_level_bit : s_r.sy2[0];
  assign rx_in = master_select_bit ? s_r.sy2[1] : s_r.sy2[2];
  assign slave_act = serial_output_enable & ~master_select_bit & ~ss_int;
  assign busy = (s_r.eng == ssdr_pkg::ENG_RUN) | (s_r.edge_cnt != 5'h00);
  assign rate = {s_r.ctrl[ssdr_pkg::C_SPR2], s_r.ctrl[ssdr_pkg::C_SPR1],
                 s_r.ctrl[ssdr_pkg::C_SPR0]};

  always_comb begin
    unique case (rate)
      3'h4: half = ssdr_pkg::HALF_2;
      3'h0: half = ssdr_pkg::HALF_4;
      3'h1: half = ssdr_pkg::HALF_8;
      3'h6: half = ssdr_pkg::HALF_16;
      3'h2: half = ssdr_pkg::HALF_32;
      default: half = ssdr_pkg::HALF_64;
    endcase
  end

  // Pins: outputs only while the port owns them
  assign sck_o = cpol ^ s_r.sck_ph;
  assign sck_oe = serial_output_enable & master_select_bit;
  assign mosi_o = s_r.out_r;
  assign miso_o = s_r.out_r;
  assign mosi_oe = serial_output_enable & master_select_bit & ~s_r.output_disable_bit;
  assign miso_oe = slave_act & ~s_r.output_disable_bit;
  assign irq = s_r.ctrl[ssdr_pkg::C_IE] & (s_r.done | s_r.mode_fault_flag | s_r.overrun_flag);

  ////////////////////////////////////////////////////////////////////
  // Next state

  logic ev;
  logic lead;
  logic cap;
  logic fin;
  logic dr_acc;
  logic dr_wr_ok;
  logic fault;

  always_comb begin
    s_nxt = s_r;
    ev = 1'b0;
    lead = 1'b0;
    s_nxt.sy1 = {sck_i, mosi_i, miso_i, ss_n_i};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sck_prev = s_r.sy2[3];

    // Serial clock edges: generated in master mode, sampled in slave mode
    if (s_r.eng == ssdr_pkg::ENG_RUN) begin
      if (s_r.div_cnt == 6'h00) begin
        s_nxt.div_cnt = half - 6'h01;
        s_nxt.sck_ph = ~s_r.sck_ph;
        ev = 1'b1;
        lead = ~s_r.sck_ph;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt - 6'h01;
      end
    end else if (slave_act && (s_r.sy2[3] != s_r.sck_prev)) begin
      ev = 1'b1;
      lead = s_r.sck_prev == cpol;
    end
    cap = ev & (lead ^ cpha);
    fin = ev & (s_r.edge_cnt == ssdr_pkg::EDGES_LAST);

    if (ev) begin
      s_nxt.edge_cnt = s_r.edge_cnt + 5'h01;
      if (cap) begin
        s_nxt.sr = {s_r.sr[6:0], rx_in};
      end else begin
        s_nxt.out_r = s_r.sr[7];
      end
    end
    if (!master_select_bit && ss_int) begin
      // Deselect abandons a partial byte
      s_nxt.edge_cnt = 5'h00;
    end

    // Register accesses
    dr_acc = acc & is_data;
    dr_wr_ok = wr & is_data & ~(s_r.done & ~s_r.seq_rd);
    if (setup) begin
      s_nxt.rdata = 8'h00;
      if (is_data) begin
        s_nxt.rdata = s_r.rxbuf;
      end else if (is_ctrl) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (is_csr) begin
        s_nxt.rdata = {s_r.done, s_r.write_collision_flag, s_r.overrun_flag, s_r.mode_fault_flag, 1'b0,
                       s_r.output_disable_bit, s_r.select_software_mgmt_bit, s_r.internal_select_level_bit};
      end
    end
    if (acc && is_csr) begin
      if (s_r.done || s_r.write_collision_flag) begin
        s_nxt.seq_any = 1'b1;
      end
      if (s_r.mode_fault_flag) begin
        s_nxt.seq_mode_fault_flag = 1'b1;
      end
      if (!pwrite) begin
        // Only a read that sees the flag unblocks; an older read must not
        if (s_r.done) begin
          s_nxt.seq_rd = 1'b1;
        end
        s_nxt.overrun_flag = 1'b0;
      end else begin
        s_nxt.output_disable_bit = pwdata[ssdr_pkg::S_SOD];
        s_nxt.select_software_mgmt_bit = pwdata[ssdr_pkg::S_SSM];
        s_nxt.internal_select_level_bit = pwdata[ssdr_pkg::S_SSI];
      end
    end
    if (wr && is_ctrl) begin
      s_nxt.ctrl = pwdata[7:0];
      if (s_r.seq_mode_fault_flag) begin
        s_nxt.mode_fault_flag = 1'b0;
        s_nxt.seq_mode_fault_flag = 1'b0;
      end
    end
    if (dr_acc && s_r.seq_any) begin
      s_nxt.done = 1'b0;
      s_nxt.write_collision_flag = 1'b0;
      s_nxt.seq_any = 1'b0;
      s_nxt.seq_rd = 1'b0;
    end
    if (dr_wr_ok) begin
      if (busy) begin
        s_nxt.write_collision_flag = 1'b1;
      end else begin
        s_nxt.sr = pwdata[7:0];
        s_nxt.out_r = pwdata[7];
        s_nxt.edge_cnt = 5'h00;
        if (serial_output_enable && master_select_bit) begin
          s_nxt.eng = ssdr_pkg::ENG_RUN;
          s_nxt.div_cnt = half - 6'h01;
          s_nxt.sck_ph = 1'b0;
        end
      end
    end

    // Byte end: flag and buffer; an unread byte is kept, not overwritten
    if (fin) begin
      s_nxt.edge_cnt = 5'h00;
      s_nxt.eng = ssdr_pkg::ENG_IDLE;
      if (s_r.done) begin
        s_nxt.overrun_flag = 1'b1;
      end else begin
        s_nxt.rxbuf = s_nxt.sr;
      end
      s_nxt.done = 1'b1;
    end

    // Select pulled low while master: fault wins over any clear
    fault = serial_output_enable & master_select_bit & ~ss_int;
    if (fault) begin
      s_nxt.mode_fault_flag = 1'b1;
      s_nxt.ctrl[ssdr_pkg::C_SPE] = 1'b0;
      s_nxt.ctrl[ssdr_pkg::C_MASTER_SELECT_BIT] = 1'b0;
      s_nxt.eng = ssdr_pkg::ENG_IDLE;
      s_nxt.sck_ph = 1'b0;
      s_nxt.edge_cnt = 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl <= ssdr_pkg::CTRL_RST;
      s_r.rxbuf <= ssdr_pkg::DATA_RST;
      s_r.sy1 <= 4'hF;
      s_r.sy2 <= 4'hF;
      // Edge detector starts level with the synchroniser: no false edge
      s_r.sck_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  done_set_a: assert property (fin |=> s_r.done)
    else $error("transfer end did not set done flag");
  done_clr_a: assert property (
    (dr_acc && s_r.seq_any && !fin) |=> !s_r.done)
    else $error("done flag not cleared by status then data access");
  dr_block_a: assert property (
    (wr && is_data && s_r.done && !s_r.seq_rd && !ev && !fault)
    |=> $stable(s_r.sr) && s_r.eng == ssdr_pkg::ENG_IDLE)
    else $error("data write taken while done flag blocks it");
  irq_done_a: assert property (
    (fin && s_r.ctrl[ssdr_pkg::C_IE] && !(wr && is_ctrl)) |=> irq)
    else $error("no interrupt after transfer end");
  write_collision_flag_set_a: assert property (
    (wr && is_data && !(s_r.done && !s_r.seq_rd) && busy) |=> s_r.write_collision_flag)
    else $error("collision not flagged");
  ovr_set_a: assert property (
    (fin && s_r.done) |=> s_r.overrun_flag && $stable(s_r.rxbuf))
    else $error("overrun not flagged or buffer overwritten");
  ovr_clr_a: assert property ((rd && is_csr && !fin) |=> !s_r.overrun_flag)
    else $error("overrun not cleared by status read");
  mode_fault_flag_set_a: assert property (
    fault |=> s_r.mode_fault_flag && !s_r.ctrl[ssdr_pkg::C_SPE] && !s_r.ctrl[ssdr_pkg::C_MASTER_SELECT_BIT])
    else $error("mode fault not handled");
  mode_fault_flag_clr_a: assert property (
    (wr && is_ctrl && s_r.seq_mode_fault_flag && !pwdata[ssdr_pkg::C_MASTER_SELECT_BIT]) |=> !s_r.mode_fault_flag)
    else $error("mode fault not cleared by control write");
  sod_a: assert property (s_r.output_disable_bit |-> !mosi_oe && !miso_oe)
    else $error("output driven while disabled");
  ssm_a: assert property (
    (s_r.select_software_mgmt_bit && s_r.internal_select_level_bit && !master_select_bit) |-> !miso_oe)
    else $error("deselected slave drives output");
  rsv_a: assert property ((setup && is_csr) |=> !s_r.rdata[ssdr_pkg::S_RSV])
    else $error("reserved status bit reads one");
  start_a: assert property (
    (dr_wr_ok && !busy && serial_output_enable && master_select_bit && !fault) |=> s_r.eng == ssdr_pkg::ENG_RUN)
    else $error("master write did not start a byte");
  rdbuf_a: assert property ((setup && is_data) |=> s_r.rdata == $past(s_r.rxbuf))
    else $error("data read not from receive buffer");

  // Flags hold until their own clear sequence
  // A set in the same cycle wins, so clear checks exclude it
  done_hold_a: assert property (
    (s_r.done && !(dr_acc && s_r.seq_any)) |=> s_r.done)
    else $error("done flag lost without clear sequence");
  write_collision_flag_clr_a: assert property (
    (dr_acc && s_r.seq_any && !(dr_wr_ok && busy)) |=> !s_r.write_collision_flag)
    else $error("collision flag not cleared by status then data access");
  write_collision_flag_hold_a: assert property (
    (s_r.write_collision_flag && !(dr_acc && s_r.seq_any)) |=> s_r.write_collision_flag)
    else $error("collision flag lost without clear sequence");
  ovr_hold_a: assert property (
    (s_r.overrun_flag && !(rd && is_csr)) |=> s_r.overrun_flag)
    else $error("overrun flag lost without status read");
  mode_fault_flag_hold_a: assert property (
    (s_r.mode_fault_flag && !(wr && is_ctrl && s_r.seq_mode_fault_flag)) |=> s_r.mode_fault_flag)
    else $error("mode fault lost without clear sequence");

  // A control write in the same cycle may drop the enable
  irq_ovr_a: assert property (
    (fin && s_r.done && s_r.ctrl[ssdr_pkg::C_IE] && !(wr && is_ctrl)) |=> irq)
    else $error("no interrupt after overrun");
  irq_mode_fault_flag_a: assert property (
    (fault && s_r.ctrl[ssdr_pkg::C_IE] && !(wr && is_ctrl)) |=> irq)
    else $error("no interrupt after mode fault");

  // Pins and select
  oe_off_a: assert property (
    !serial_output_enable |-> !mosi_oe && !miso_oe && !sck_oe)
    else $error("pin driven while port disabled");
  ssi_sel_a: assert property (
    (s_r.select_software_mgmt_bit && !s_r.internal_select_level_bit && serial_output_enable && !master_select_bit && !s_r.output_disable_bit) |-> miso_oe)
    else $error("selected slave does not drive output");
  ssm_pin_a: assert property (
    (s_r.select_software_mgmt_bit && s_r.internal_select_level_bit && !s_r.mode_fault_flag) |=> !s_r.mode_fault_flag)
    else $error("select pin not ignored under software select");

  // Data path and reset values
  rxbuf_load_a: assert property (
    (fin && !s_r.done) |=> s_r.rxbuf == s_r.sr)
    else $error("received byte not copied to buffer");
  dr_load_a: assert property (
    (dr_wr_ok && !busy) |=> s_r.sr == $past(pwdata[7:0]))
    else $error("accepted data write not in shift register");
  rst_vals_a: assert property (
    $rose(presetn) |-> s_r.ctrl == ssdr_pkg::CTRL_RST &&
      !(s_r.done | s_r.write_collision_flag | s_r.overrun_flag | s_r.mode_fault_flag | s_r.output_disable_bit | s_r.select_software_mgmt_bit | s_r.internal_select_level_bit))
    else $error("register not at reset value");

  master_byte_c: cover property (s_r.eng == ssdr_pkg::ENG_RUN ##1 fin);
  slave_byte_c: cover property (slave_act && fin);
  overrun_c: cover property (fin && s_r.done);
  fault_c: cover property (fault);
  collision_c: cover property (wr && is_data && busy);

endmodule

// [design/ssdr_pkg.sv]
// Constants of the serial port register block: map, fields, resets.
// Assumes APB with 32-bit data; registers sit in the low byte lanes.
package ssdr_pkg;
  localparam logic [7:0] IDX_DATA = 8'h19;
  localparam logic [7:0] IDX_CTRL = 8'h1A;
  localparam logic [7:0] IDX_CSR = 8'h1B;
  localparam logic [7:0] A_DATA = {IDX_DATA[5:0], 2'b00};
  localparam logic [7:0] A_CTRL = {IDX_CTRL[5:0], 2'b00};
  localparam logic [7:0] A_CSR = {IDX_CSR[5:0], 2'b00};
  localparam int C_IE = 7;
  localparam int C_SPE = 6;
  localparam int C_SPR2 = 5;
  localparam int C_MASTER_SELECT_BIT = 4;
  localparam int C_CPOL = 3;
  localparam int C_CPHA = 2;
  localparam int C_SPR1 = 1;
  localparam int C_SPR0 = 0;
  localparam int S_DONE = 7;
  localparam int S_WRITE_COLLISION_FLAG = 6;
  localparam int S_OVR = 5;
  localparam int S_MODE_FAULT_FLAG = 4;
  localparam int S_RSV = 3;
  localparam int S_SOD = 2;
  localparam int S_SSM = 1;
  localparam int S_SSI = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] EDGES_LAST = 5'h0F;
  // Half periods of the serial clock in pclk cycles, per rate code
  localparam logic [5:0] HALF_2 = 6'h01;
  localparam logic [5:0] HALF_4 = 6'h02;
  localparam logic [5:0] HALF_8 = 6'h04;
  localparam logic [5:0] HALF_16 = 6'h08;
  localparam logic [5:0] HALF_32 = 6'h10;
  localparam logic [5:0] HALF_64 = 6'h20;
  typedef enum logic {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} ssdr_eng_e;
endpackage

// [tb/ssdr_slave_model.sv]
// Far-side serial slave: mode 0 timing, shifts MSB first.
// Assumes the block is master; selected by the bench before each byte.
`timescale 1ns/1ps
module ssdr_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  always @(negedge sel_n) begin
    sh = tx;
    miso = tx[7];
  end
  // Released line: show the inverse so a stale bit never looks valid
  always @(posedge sel_n) miso = ~miso;
  always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
  always @(negedge sck) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule

// [tb/tb.sv]
// Self-checking bench of the serial register block over APB.
// Assumes zero-wait APB slave and a slave model on the serial pins.
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, e;
  logic sck_in = 1'b0, mosi_in = 1'b0, ss_pin = 1'b1, sel_n = 1'b1, smiso;
  logic [7:0] stx = 8'h3C, srx, so;
  int num_errors = 0, checks_done = 0, cyc = 0;
  always #10 pclk = ~pclk;
  ssdr_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sck_i(sck_in), .sck_o(sck_o), .sck_oe(sck_oe),
    .mosi_i(mosi_in), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(smiso),
    .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_pin));
  ssdr_slave_model slv (.sck(sck_o), .mosi(mosi_o), .sel_n(sel_n), .tx(stx),
    .miso(smiso), .rx(srx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(n, x, q[7:0]);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Mode 0 byte at an 8-cycle serial period, data set before the rising edge
  task automatic sbyte(input logic [7:0] b, output logic [7:0] o);
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= b[i];
      repeat (4) @(posedge pclk);
      o = {o[6:0], miso_o};
      sck_in <= 1'b1;
      repeat (4) @(posedge pclk);
      sck_in <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd("csr", ssdr_pkg::A_CSR, 8'h00);
    rd("ctrl", ssdr_pkg::A_CTRL, 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk("slverr", 8'h01, {7'h00, e});
  endtask
  task automatic t_master();
    apb(1'b1, ssdr_pkg::A_CTRL, 8'hD1);
    apb(1'b1, ssdr_pkg::A_CSR, 8'h0F);
    rd("csr", ssdr_pkg::A_CSR, 8'h07);
    chk("oe", 8'h02, {6'h00, sck_oe, mosi_oe});
    apb(1'b1, ssdr_pkg::A_CSR, 8'h00);
    chk("oe", 8'h03, {6'h00, sck_oe, mosi_oe});
    sel_n <= 1'b0;
    apb(1'b1, ssdr_pkg::A_DATA, 8'hA5);
    apb(1'b1, ssdr_pkg::A_DATA, 8'h77);
    wait_irq();
    chk("irq", 8'h01, {7'h00, irq});
    sel_n <= 1'b1;
    chk("slave_rx", 8'hA5, srx);
    rd("csr", ssdr_pkg::A_CSR, 8'hC0);
    rd("data", ssdr_pkg::A_DATA, 8'h3C);
    rd("csr", ssdr_pkg::A_CSR, 8'h00);
  endtask
  task automatic t_block();
    stx = 8'h96;
    sel_n <= 1'b0;
    apb(1'b1, ssdr_pkg::A_DATA, 8'h5B);
    wait_irq();
    // Slave stays selected so a wrongly taken write would reach it
    apb(1'b1, ssdr_pkg::A_DATA, 8'h11);
    repeat (100) @(posedge pclk);
    sel_n <= 1'b1;
    chk("slave_rx", 8'h5B, srx);
    rd("csr", ssdr_pkg::A_CSR, 8'h80);
    rd("data", ssdr_pkg::A_DATA, 8'h96);
    rd("csr", ssdr_pkg::A_CSR, 8'h00);
  endtask
  task automatic t_fault();
    ss_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("irq", 8'h01, {7'h00, irq});
    rd("csr", ssdr_pkg::A_CSR, 8'h10);
    rd("ctrl", ssdr_pkg::A_CTRL, 8'h81);
    ss_pin <= 1'b1;
    apb(1'b1, ssdr_pkg::A_CTRL, 8'h00);
    rd("csr", ssdr_pkg::A_CSR, 8'h00);
  endtask
  task automatic t_slave();
    apb(1'b1, ssdr_pkg::A_CTRL, 8'h40);
    apb(1'b1, ssdr_pkg::A_CSR, 8'h03);
    chk("miso_oe", 8'h00, {7'h00, miso_oe});
    apb(1'b1, ssdr_pkg::A_CSR, 8'h02);
    chk("miso_oe", 8'h01, {7'h00, miso_oe});
    apb(1'b1, ssdr_pkg::A_DATA, 8'hC3);
    sbyte(8'h5A, so);
    chk("miso", 8'hC3, so);
    sbyte(8'h66, so);
    rd("csr", ssdr_pkg::A_CSR, 8'hA2);
    rd("data", ssdr_pkg::A_DATA, 8'h5A);
    rd("csr", ssdr_pkg::A_CSR, 8'h02);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_master();
    t_block();
    t_fault();
    t_slave();
    conclude();
  end
endmodule
